// file: inc/hpm_regs.vh
// constants for the host port pin mode and strap block
`ifndef HPM_REGS_VH
`define HPM_REGS_VH
`define HPM_MODE_W 2
`define HPM_MODE_PAR 2'h0
`define HPM_MODE_I2C 2'h1
`define HPM_MODE_VIP 2'h2
`define HPM_ID_W 16
`define HPM_ID_RST 16'h0000
`define HPM_ID_A_HI 13
`define HPM_ID_A_LO 12
`define HPM_ID_D_HI 7
`define HPM_ID_D_LO 0
`define HPM_VID_W 10
`define HPM_ST_RESET 2'h0
`define HPM_ST_SAMPLE 2'h1
`define HPM_ST_RUN 2'h2
`endif

// file: hw/hpm_sync.v
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module hpm_sync (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_pin,
  output reg o_level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // first stage read only by second; level changes when stages 2 and 3 agree
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule

// file: hw/hpm_pin_mux.v
// host port pin mode selection, strap capture and video output enable
// Summary of operation
// - VIP reset: address pins load ID[13:12]
// - VIP reset: data pins load ID[7:0]
// - pulled high gives 1, otherwise 0
// - weak pulldown stays on after reset
// - parallel mode: address and bidirectional data ports
// - parallel/I2C: interrupt pin carries request, open drain
// - VIP: interrupt pin is VIP request, no pulldown
// - ctrl pin0: acknowledge, SCL, VIP address 0
// - ctrl pin1: write strobe, SDA, VIP address 1
// - ctrl pin2: data strobe read, or HCTL
// - ctrl pin3 input: select, address select, VIPCLK
// - output enable high floats luma and chroma
// - host port may also disable video outputs
// - reset input active low, straps sampled then
// - drive active-low reset output for board
// - mode from colour pll, pal and field pins
`timescale 1ns/1ps
`include "hpm_regs.vh"
module hpm_pin_mux (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_reset_in_n,
  input wire i_colour_pll_serial_pin,
  input wire i_pal_line_indicator,
  input wire i_field_id_pin,
  input wire [1:0] i_addr_pin,
  input wire [7:0] i_data_pin,
  output reg [7:0] o_data_pin,
  output reg o_data_pin_oe,
  output reg o_addr_pulldown_en,
  output reg o_data_pulldown_en,
  output reg o_interrupt_request_pin,
  output reg o_interrupt_request_pin_oe,
  output reg o_interrupt_pulldown_en,
  input wire i_host_ctrl_pin0,
  output reg o_host_ctrl_pin0,
  output reg o_host_ctrl_pin0_oe,
  input wire i_host_ctrl_pin1,
  output reg o_host_ctrl_pin1,
  output reg o_host_ctrl_pin1_oe,
  input wire i_host_ctrl_pin2,
  input wire i_host_ctrl_pin3,
  input wire i_video_output_enable_n,
  output reg o_video_oe,
  output reg o_reset_out_n,
  output reg [`HPM_MODE_W-1:0] o_mode,
  output reg [`HPM_ID_W-1:0] o_subsys_id,
  input wire i_irq,
  input wire i_irq_open_drain,
  input wire i_host_video_disable,
  input wire [7:0] i_host_rdata,
  input wire i_host_rdata_en,
  input wire i_data_acknowledge,
  input wire i_i2c_sda_low,
  input wire i_i2c_scl_low,
  output reg [1:0] o_host_addr,
  output reg [7:0] o_host_wdata,
  output reg o_host_write_strobe,
  output reg o_data_strobe_read,
  output reg o_chip_select,
  output reg o_scl,
  output reg o_sda,
  output reg o_slave_address_select,
  output reg o_vip_clk,
  output reg [1:0] o_vip_had,
  output reg o_vip_hctl
);
  // synchronised pin levels
  wire rst_n_s;
  wire pll_s;
  wire pal_s;
  wire fid_s;
  wire oe_n_s;
  wire c0_s;
  wire c1_s;
  wire c2_s;
  wire c3_s;
  wire [1:0] a_s;
  wire [7:0] d_s;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`HPM_MODE_W-1:0] mode_d;
  reg [`HPM_ID_W-1:0] id_d;
  // decoded mode and run state
  wire is_par;
  wire is_i2c;
  wire is_vip;
  wire running;

  // all outside pins pass through the filtered synchroniser
  hpm_sync u_rst (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_reset_in_n),
    .o_level(rst_n_s));
  hpm_sync u_pll (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_pin(i_colour_pll_serial_pin), .o_level(pll_s));
  hpm_sync u_pal (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_pin(i_pal_line_indicator), .o_level(pal_s));
  hpm_sync u_fid (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_field_id_pin),
    .o_level(fid_s));
  hpm_sync u_oe (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_pin(i_video_output_enable_n), .o_level(oe_n_s));
  hpm_sync u_c0 (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_host_ctrl_pin0),
    .o_level(c0_s));
  hpm_sync u_c1 (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_host_ctrl_pin1),
    .o_level(c1_s));
  hpm_sync u_c2 (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_host_ctrl_pin2),
    .o_level(c2_s));
  hpm_sync u_c3 (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_host_ctrl_pin3),
    .o_level(c3_s));

  // address and data strap pins
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_a
      hpm_sync u_a (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_addr_pin[gi]),
        .o_level(a_s[gi]));
    end
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_d
      hpm_sync u_d (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_pin(i_data_pin[gi]),
        .o_level(d_s[gi]));
    end
  endgenerate

  // mode decode helpers
  assign is_par = (o_mode == `HPM_MODE_PAR);
  assign is_i2c = (o_mode == `HPM_MODE_I2C);
  assign is_vip = (o_mode == `HPM_MODE_VIP);
  assign running = (state_q == `HPM_ST_RUN);

  // reset sequencer: hold, sample mode on release, then run
  always @* begin
    state_d = state_q;
    mode_d = o_mode;
    id_d = o_subsys_id;
    case (state_q)
      `HPM_ST_RESET: begin
        if (rst_n_s) begin
          state_d = `HPM_ST_SAMPLE;
        end
      end
      `HPM_ST_SAMPLE: begin
        // mode from three pins
        // colour pll level wins, so a vip board never lands in i2c
        if (pll_s) begin
          mode_d = `HPM_MODE_VIP;
        end else if (pal_s | fid_s) begin
          mode_d = `HPM_MODE_I2C;
        end else begin
          mode_d = `HPM_MODE_PAR;
        end
        state_d = `HPM_ST_RUN;
      end
      `HPM_ST_RUN: begin
        // mode held until reset
        // a low reset pin drops back to hold and frees every driver
        if (!rst_n_s) begin
          state_d = `HPM_ST_RESET;
        end
      end
      default: begin
        state_d = `HPM_ST_RESET;
      end
    endcase
    // straps follow the pins for the whole reset interval, so the level
    // seen just before release is kept; mode is the one fixed at last run
    // address and data straps captured
    if (!rst_n_s && is_vip) begin
      id_d[`HPM_ID_A_HI:`HPM_ID_A_LO] = a_s;
      id_d[`HPM_ID_D_HI:`HPM_ID_D_LO] = d_s;
    end
  end

  // state, mode and captured identity
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= `HPM_ST_RESET;
      o_mode <= `HPM_MODE_PAR;
      o_subsys_id <= `HPM_ID_RST;
    end else begin
      state_q <= state_d;
      o_mode <= mode_d;
      o_subsys_id <= id_d;
    end
  end

  // board reset output and strap pulldowns
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reset_out_n <= 1'b0;
      o_addr_pulldown_en <= 1'b1;
      o_data_pulldown_en <= 1'b1;
    end else begin
      // board reset output
      // follows the run state, so it stays low through mode sampling
      o_reset_out_n <= running;
      o_addr_pulldown_en <= 1'b1;
      o_data_pulldown_en <= 1'b1;
    end
  end

  // parallel host address and data port
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data_pin <= 8'h00;
      o_data_pin_oe <= 1'b0;
      o_host_addr <= 2'h0;
      o_host_wdata <= 8'h00;
    end else begin
      o_host_addr <= (running && is_par) ? a_s : 2'h0;
      o_host_wdata <= (running && is_par) ? d_s : 8'h00;
      // the drive value is free running; only the enable gates the pins
      o_data_pin <= i_host_rdata;
      // data pins stay inputs outside parallel mode so straps read cleanly
      o_data_pin_oe <= running && is_par && i_host_rdata_en;
    end
  end

  // interrupt pin drive
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_interrupt_request_pin <= 1'b0;
      o_interrupt_request_pin_oe <= 1'b0;
      o_interrupt_pulldown_en <= 1'b1;
    end else begin
      o_interrupt_pulldown_en <= !is_vip;
      if (is_vip || i_irq_open_drain) begin
        // open drain: only pull low, the board pullup gives the idle level
        o_interrupt_request_pin <= 1'b0;
        o_interrupt_request_pin_oe <= running && i_irq;
      end else begin
        o_interrupt_request_pin <= i_irq;
        o_interrupt_request_pin_oe <= running;
      end
    end
  end

  // control pins 0 and 1: acknowledge, write strobe, i2c lines, vip address
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_host_ctrl_pin0 <= 1'b0;
      o_host_ctrl_pin0_oe <= 1'b0;
      o_host_ctrl_pin1 <= 1'b0;
      o_host_ctrl_pin1_oe <= 1'b0;
      o_host_write_strobe <= 1'b0;
      o_scl <= 1'b1;
      o_sda <= 1'b1;
      o_vip_had <= 2'h0;
    end else begin
      o_host_ctrl_pin0 <= is_par ? i_data_acknowledge : 1'b0;
      o_host_ctrl_pin0_oe <= running && (is_par || (is_i2c && i_i2c_scl_low));
      o_scl <= is_i2c ? c0_s : 1'b1;
      // ctrl pin1 function
      // i2c lines are open drain: value stays low, only the enable moves
      o_host_ctrl_pin1 <= 1'b0;
      o_host_ctrl_pin1_oe <= running && is_i2c && i_i2c_sda_low;
      o_host_write_strobe <= running && is_par && c1_s;
      o_sda <= is_i2c ? c1_s : 1'b1;
      o_vip_had <= is_vip ? {c1_s, c0_s} : 2'h0;
    end
  end

  // control pins 2 and 3: strobes, chip select, vip control and clock
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data_strobe_read <= 1'b0;
      o_chip_select <= 1'b0;
      o_slave_address_select <= 1'b0;
      o_vip_clk <= 1'b0;
      o_vip_hctl <= 1'b0;
    end else begin
      o_data_strobe_read <= running && is_par && c2_s;
      o_vip_hctl <= is_vip && c2_s;
      // ctrl pin3 input only
      // pin3 is never driven, so it has no enable of its own
      o_chip_select <= running && is_par && c3_s;
      o_slave_address_select <= is_i2c && c3_s;
      o_vip_clk <= is_vip && c3_s;
    end
  end

  // luma and chroma output enable
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_video_oe <= 1'b0;
    end else begin
      // host port disable
      // either the pin or the host port alone can float the outputs
      o_video_oe <= running && !oe_n_s && !i_host_video_disable;
    end
  end
endmodule

// file: tb/hpm_checker.sv
// assertion checker for the host port pin mode and strap block
`timescale 1ns/1ps
module hpm_checker (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_reset_in_n,
  input wire i_video_output_enable_n,
  input wire i_host_video_disable,
  input wire o_video_oe,
  input wire o_reset_out_n,
  input wire o_addr_pulldown_en,
  input wire o_data_pulldown_en,
  input wire o_interrupt_pulldown_en,
  input wire [1:0] o_mode,
  input wire [15:0] o_subsys_id
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  AST_RST_HOLD: assert property (!i_reset_in_n [*8] |-> !o_reset_out_n)
    else $error("reset out high in reset");
  AST_RST_RUN: assert property ($rose(i_reset_in_n) ##1 i_reset_in_n [*8] |-> o_reset_out_n)
    else $error("reset out late");
  AST_VID_PIN: assert property (i_video_output_enable_n [*8] |-> !o_video_oe)
    else $error("video driven with pin off");
  AST_VID_HOST: assert property (i_host_video_disable [*8] |-> !o_video_oe)
    else $error("video driven with host off");
  AST_PULLDOWN: assert property (o_addr_pulldown_en && o_data_pulldown_en)
    else $error("strap pulldown off");
  AST_VIP_NOPD: assert property (o_mode == 2'h2 && o_reset_out_n |-> !o_interrupt_pulldown_en)
    else $error("irq pulldown on in vip");
  AST_MODE_HOLD: assert property (o_reset_out_n && $past(o_reset_out_n) |-> $stable(o_mode))
    else $error("mode changed while running");
  // straps still land up to four edges after the reset pin rises
  AST_ID_HOLD: assert property (i_reset_in_n [*6] |-> $stable(o_subsys_id))
    else $error("id changed while running");
  // main scenarios reached
  cover property ($rose(o_reset_out_n) && o_mode == 2'h2);
  cover property ($rose(o_video_oe));
  cover property (o_subsys_id != 16'h0000);
endmodule
bind hpm_pin_mux hpm_checker u_chk (.*);

// file: tb/hpm_host_model.sv
// far-side host model: strap resistors, shared data wire, vip clock
`timescale 1ns/1ps
module hpm_host_model (
  input wire logic i_clk_en,
  input wire logic [1:0] i_a_pull,
  input wire logic [7:0] i_d_pull,
  input wire logic [7:0] i_dev_d,
  input wire logic i_dev_d_oe,
  output logic [1:0] o_a,
  output logic [7:0] o_d,
  output logic o_vclk
);
  // fitted pull-up reads 1, else pulldown reads 0
  assign o_a = i_a_pull;
  // device driver wins, else the resistors decide
  assign o_d = i_dev_d_oe ? i_dev_d : i_d_pull;
  // clock runs only while enabled, stands low otherwise
  initial begin
    o_vclk = 0;
    #7;
    forever #80 o_vclk = i_clk_en & ~o_vclk;
  end
endmodule

// file: tb/tb_hpm_pin_mux.sv
// self-checking bench for the host port pin mode and strap block
`timescale 1ns/1ps
module tb_hpm_pin_mux;
  logic clk, rst, rin_n, pll, pal, field_id_pin, ven_n, hdis, ven, dq_oe, ro_n, voe, cs, vclk, sas, vh;
  logic [1:0] ap, apu, ha, mode, had;
  logic [7:0] dp, dpu, dq, wd;
  logic apd, dpd, irqp, irqoe, irqpd, c0o, c0oe, c1o, c1oe, wstb, dsr, scl, sda, vco;
  logic [3:0] c;
  logic [13:0] m;
  logic [15:0] id;
  int e, n_fail = 0, checks_done = 0;
  int vq[$];
  hpm_host_model far (.i_clk_en(ven), .i_a_pull(apu), .i_d_pull(dpu), .i_dev_d(dq),
    .i_dev_d_oe(dq_oe), .o_a(ap), .o_d(dp), .o_vclk(vclk));
  hpm_pin_mux uut (.i_sys_clk(clk), .i_reset(rst), .i_reset_in_n(rin_n),
    .i_colour_pll_serial_pin(pll), .i_pal_line_indicator(pal), .i_field_id_pin(field_id_pin),
    .i_addr_pin(ap), .i_data_pin(dp), .o_data_pin(dq), .o_data_pin_oe(dq_oe),
    .o_addr_pulldown_en(apd), .o_data_pulldown_en(dpd), .o_interrupt_request_pin(irqp),
    .o_interrupt_request_pin_oe(irqoe), .o_interrupt_pulldown_en(irqpd),
    .i_host_ctrl_pin0(c[0]), .o_host_ctrl_pin0(c0o), .o_host_ctrl_pin0_oe(c0oe),
    .i_host_ctrl_pin1(c[1]), .o_host_ctrl_pin1(c1o), .o_host_ctrl_pin1_oe(c1oe),
    .i_host_ctrl_pin2(c[2]), .i_host_ctrl_pin3(ven ? vclk : c[3]),
    .i_video_output_enable_n(ven_n), .o_video_oe(voe), .o_reset_out_n(ro_n),
    .o_mode(mode), .o_subsys_id(id), .i_irq(m[0]), .i_irq_open_drain(m[1]),
    .i_host_video_disable(hdis), .i_host_rdata(m[9:2]), .i_host_rdata_en(m[10]),
    .i_data_acknowledge(m[11]), .i_i2c_sda_low(m[12]), .i_i2c_scl_low(m[13]),
    .o_host_addr(ha), .o_host_wdata(wd), .o_host_write_strobe(wstb),
    .o_data_strobe_read(dsr), .o_chip_select(cs), .o_scl(scl), .o_sda(sda),
    .o_slave_address_select(sas), .o_vip_clk(vco), .o_vip_had(had), .o_vip_hctl(vh));
  task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hold the board reset pin low with straps set, then wait for run
  task automatic pin_reset(logic [2:0] s, logic [9:0] st);
    {pll, pal, field_id_pin} = s;
    {apu, dpu} = st;
    rin_n = 0;
    repeat (12) @(negedge clk);
    rin_n = 1;
    for (int i = 0; i < 40 && ro_n !== 1'b1; i++) @(negedge clk);
    if (ro_n !== 1'b1) begin
      chk("reset_out", 1'b1, ro_n);
      end_of_test();
    end
  endtask
  // link clock history: the design's view lags the pin by four edges
  always @(posedge clk) begin
    vq.push_back(vclk);
    if (vq.size() > 5) void'(vq.pop_front());
  end
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rin_n, pll, pal, field_id_pin, ven_n, hdis, ven, apu, dpu, c, m} = 0;
    rst = 1;
    void'($urandom(55));
    repeat (8) @(negedge clk);
    rst = 0;
    // every mode pin combination, then pins per mode with random levels
    for (int k = 0; k < 8; k++) begin
      pin_reset(k[2:0], 10'h000);
      e = k[2] ? 2 : (k[1:0] != 0);
      {pll, pal, field_id_pin} = ~k[2:0];
      ven = (e == 2);
      {c, m, apu, dpu, ven_n, hdis} = $urandom;
      repeat (8) @(negedge clk);
      chk("mode", e, mode);
      chk("video_oe", !(ven_n | hdis), voe);
      chk("pulldowns", 2'h3, {apd, dpd});
      chk("irq_pd", e != 2, irqpd);
      chk("irq", (e == 2 || m[1]) ? {1'b0, m[0]} : {m[0], 1'b1}, {irqp, irqoe});
      chk("ctrl0", {e == 0 && m[11], e == 0 || (e == 1 && m[13])}, {c0o, c0oe});
      chk("ctrl1", {1'b0, e == 1 && m[12]}, {c1o, c1oe});
      chk("i2c", (e == 1) ? c[1:0] : 2'h3, {sda, scl});
      chk("par_strobes", (e == 0) ? c[2:1] : 2'h0, {dsr, wstb});
      if (e == 0) chk("data_drive", {m[10], m[9:2]}, {dq_oe, dq});
      if (e == 0) chk("wdata", m[10] ? m[9:2] : dpu, wd);
      if (e == 0) chk("addr", ap, ha);
      if (e == 0) chk("cs", c[3], cs);
      if (e == 1) chk("addr_sel", c[3], sas);
      if (e == 2) chk("vip_pins", c[2:0], {vh, had});
      for (int i = 0; i < 16 && e == 2; i++) begin
        @(negedge clk);
        chk("vip_clk", vq[0], vco);
      end
    end
    // strap capture in vip mode with random resistor fits
    repeat (4) begin
      e = $urandom;
      pin_reset(3'h4, e[9:0]);
      chk("id", {2'h0, e[9:8], 4'h0, e[7:0]}, id);
    end
    end_of_test();
  end
endmodule
